// [inc/csi_pkg.sv]
// shared constants and carrier types of the slot-based serial master
package csi_pkg;
  // clock and serial rate
  localparam int CLK_KHZ = 40000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_RATE_KBPS = 1000;
  localparam int HALF_BIT_CYC = CLK_KHZ / (2 * BIT_RATE_KBPS);
  localparam logic [4:0] HALF_LAST = 5'(HALF_BIT_CYC - 1);
  localparam logic [3:0] HALF_FINAL = 4'hf;
  localparam int CHAR_BITS = 8;

  // slot timer: prescaler then interval count
  localparam int SLOT_PRESCALE = 128;
  localparam int SLOT_US = 1000;
  localparam int SLOT_TICKS = (CLK_KHZ / 1000) * SLOT_US / SLOT_PRESCALE;
  localparam logic [6:0] PRE_LAST = 7'(SLOT_PRESCALE - 1);
  localparam logic [8:0] SLOT_LAST = 9'(SLOT_TICKS - 1);

  // busy handshake timeout, longest time rounds down
  localparam int TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [8:0] TMO_LAST = 9'(TIMEOUT_CYC - 1);

  // commands and buffers
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [1:0] OP_RX = 2'h1;
  localparam logic [1:0] OP_TX = 2'h2;
  localparam logic [1:0] OP_TRX = 2'h3;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [7:0] TX_FIRST = 8'h00;
  localparam logic [7:0] TX_STEP = 8'h01;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  // sequence phases, one per slot
  localparam logic [1:0] PH_STATUS = 2'h0;
  localparam logic [1:0] PH_TX = 2'h1;
  localparam logic [1:0] PH_TRX = 2'h2;
  localparam logic [1:0] PH_RX = 2'h3;

  // outgoing link pins
  typedef struct packed {
    logic serial_clock_out;
    logic serial_data_out;
    logic slave_one_select_n;
    logic slave_two_select_n;
  } csi_pins_t;
endpackage

// [src/csi_shifter.sv]
// one-character shifter: 8 bits, msb first, clock idle high, type 1 phase
`timescale 1ns/1ps
module csi_shifter (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic sdi,
  output logic sck,
  output logic sdo,
  output logic [7:0] rx_byte,
  output logic done
);
  import csi_pkg::*;

  typedef struct packed {
    logic act;
    logic [4:0] div;
    logic [3:0] half;
    logic sck;
    logic sdo;
    logic [7:0] tx;
    logic [7:0] rx;
    logic done;
  } sh_t;

  sh_t q;
  sh_t d;

  // sixteen half periods: falling edge drives a bit, rising edge samples one
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!q.act) begin
      if (start) begin
        d.act = 1'b1;
        d.div = '0;
        d.half = '0;
        d.tx = tx_byte;
      end
    end else if (q.div == HALF_LAST) begin
      d.div = '0;
      if (!q.half[0]) begin
        d.sck = 1'b0;
        d.sdo = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end else begin
        d.sck = 1'b1;
        d.rx = {q.rx[6:0], sdi};
      end
      d.half = q.half + 4'h1;
      // done after exactly eight rising edges
      if (q.half == HALF_FINAL) begin
        d.act = 1'b0;
        d.done = 1'b1;
      end
    end else begin
      d.div = q.div + 5'h01;
    end
  end

  // register the shifter state; clock and data reset high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.sck <= 1'b1;
      q.sdo <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sck = q.sck;
  assign sdo = q.sdo;
  assign rx_byte = q.rx;
  assign done = q.done;
endmodule

// [src/csi_master_slot_handshake.sv]
// slot-based serial master alternating between two busy-handshaking slaves
`timescale 1ns/1ps
module csi_master_slot_handshake (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_data_in,
  input wire logic busy_in,
  output csi_pkg::csi_pins_t pins_o,
  output logic transfer_end_irq,
  output logic slot_tick_irq,
  output logic target_slave_flag,
  output logic halted
);
  import csi_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_SEL_WAIT = 8'h02,
    ST_CMD = 8'h04,
    ST_CMD_WAIT = 8'h08,
    ST_DATA = 8'h10,
    ST_FINISH = 8'h20,
    ST_ABORT = 8'h40,
    ST_HALT = 8'h80
  } state_t;

  typedef struct packed {
    state_t st;
    logic busy_s1;
    logic busy_s2;
    logic sdi_s1;
    logic sdi_s2;
    logic [6:0] pre;
    logic [8:0] slot;
    logic tick;
    logic [8:0] tmo;
    logic [1:0] phase;
    logic flag;
    logic [3:0] cnt;
    logic [3:0] idx;
    logic sel;
    logic launched;
    logic start;
    logic [7:0] txb;
    logic [1:0][7:0][7:0] txbuf;
    logic [1:0][7:0][7:0] expbuf;
  } ctl_t;

  ctl_t q;
  ctl_t d;
  logic sh_sck;
  logic sh_sdo;
  logic [7:0] sh_rx;
  logic sh_done;
  logic [3:0] nbytes;
  logic [1:0] op;
  logic [7:0] cmd_byte;
  logic [7:0] exp_byte;
  logic [7:0] buf_byte;

  csi_shifter u_shift (
    .clk(clk),
    .rst_b(rst_b),
    .start(q.start),
    .tx_byte(q.txb),
    .sdi(q.sdi_s2),
    .sck(sh_sck),
    .sdo(sh_sdo),
    .rx_byte(sh_rx),
    .done(sh_done)
  );

  // command fields for the current phase
  always_comb begin
    case (q.phase)
      PH_TX: op = OP_TX;
      PH_TRX: op = OP_TRX;
      PH_RX: op = OP_RX;
      default: op = 2'h0;
    endcase
    if (q.phase == PH_STATUS) begin
      cmd_byte = CMD_STATUS;
      nbytes = 4'h1;
    end else begin
      cmd_byte = {op, 2'h0, q.cnt};
      nbytes = q.cnt;
    end
    exp_byte = q.expbuf[q.flag][q.idx[2:0]];
    buf_byte = q.txbuf[q.flag][q.idx[2:0]];
  end

  // sequence control; all timers live in the same state copy
  always_comb begin
    d = q;
    d.start = 1'b0;
    d.tick = 1'b0;
    // two-stage synchronisers for the pin inputs
    d.busy_s1 = busy_in;
    d.busy_s2 = q.busy_s1;
    d.sdi_s1 = serial_data_in;
    d.sdi_s2 = q.sdi_s1;
    // free-running prescaler and interval count give the slot event
    d.pre = q.pre + 7'h01;
    if (q.pre == PRE_LAST) begin
      d.pre = '0;
      d.slot = q.slot + 9'h001;
      if (q.slot == SLOT_LAST) begin
        d.slot = '0;
        d.tick = 1'b1;
      end
    end
    // the timeout counter runs in every state but ST_IDLE; it is cleared before each busy wait
    d.tmo = q.tmo + 9'h001;

    case (q.st)
      // a slot event that lands mid-sequence is skipped, not queued
      ST_IDLE: begin
        d.tmo = '0;
        if (q.tick) begin
          d.sel = 1'b1;
          d.st = ST_SEL_WAIT;
        end
      end
      ST_SEL_WAIT, ST_CMD_WAIT: begin
        if (!q.busy_s2) begin
          d.launched = 1'b0;
          d.idx = '0;
          d.st = (q.st == ST_SEL_WAIT) ? ST_CMD : ST_DATA;
        end else if (q.tmo == TMO_LAST) begin
          d.st = ST_ABORT;
        end
      end
      ST_CMD: begin
        if (!q.launched) begin
          d.start = 1'b1;
          d.txb = cmd_byte;
          d.launched = 1'b1;
        end else if (sh_done) begin
          d.launched = 1'b0;
          d.tmo = '0;
          d.st = ST_CMD_WAIT;
        end
      end
      ST_DATA: begin
        if (q.idx == nbytes) begin
          d.st = ST_FINISH;
        end else if (!q.launched) begin
          d.start = 1'b1;
          d.launched = 1'b1;
          if (q.phase == PH_TX || q.phase == PH_TRX) begin
            d.txb = buf_byte;
          end else begin
            d.txb = IDLE_BYTE;
          end
        end else if (sh_done) begin
          d.launched = 1'b0;
          d.idx = q.idx + 4'h1;
          if (q.phase == PH_STATUS) begin
            // direction bits are not needed: every sequence runs its ops in the fixed phase order
            if (sh_rx[5:0] > {2'h0, BUF_DEPTH}) begin
              d.cnt = BUF_DEPTH;
            end else begin
              d.cnt = sh_rx[3:0];
            end
          end else if (q.phase != PH_TX && sh_rx != exp_byte) begin
            d.sel = 1'b0;
            d.st = ST_HALT;
          end
        end
      end
      ST_FINISH: begin
        d.sel = 1'b0;
        if (q.phase == PH_TX || q.phase == PH_TRX) begin
          // expectations are the complement of what just went out
          for (int i = 0; i < 8; i++) begin
            d.expbuf[q.flag][i] = ~q.txbuf[q.flag][i];
            d.txbuf[q.flag][i] = q.txbuf[q.flag][i] + TX_STEP;
          end
        end
        if (q.phase == PH_RX) begin
          d.phase = PH_STATUS;
          d.flag = ~q.flag;
        end else begin
          d.phase = q.phase + 2'h1;
        end
        d.st = ST_IDLE;
      end
      ST_ABORT: begin
        d.sel = 1'b0;
        d.phase = PH_STATUS;
        d.flag = ~q.flag;
        d.st = ST_IDLE;
      end
      // only a reset leaves the halted state
      ST_HALT: begin
        d.sel = 1'b0;
      end
      default: begin
        d.sel = 1'b0;
        d.st = ST_IDLE;
      end
    endcase
  end

  // register the control state; transmit buffers start on the increment pattern
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.busy_s1 <= 1'b1;
      q.busy_s2 <= 1'b1;
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 8; i++) begin
          q.txbuf[s][i] <= TX_FIRST + 8'(i);
        end
      end
    end else begin
      q <= d;
    end
  end

  // pins: selects are low only while their slave is addressed
  assign pins_o.serial_clock_out = sh_sck;
  assign pins_o.serial_data_out = sh_sdo;
  assign pins_o.slave_one_select_n = ~(q.sel & ~q.flag);
  assign pins_o.slave_two_select_n = ~(q.sel & q.flag);
  assign transfer_end_irq = sh_done;
  assign slot_tick_irq = q.tick;
  assign target_slave_flag = q.flag;
  assign halted = (q.st == ST_HALT);
endmodule

// [bench/csi_checker.sv]
// link timing and select assertions for the slot master
`timescale 1ns/1ps
module csi_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic busy_in,
  input wire csi_pkg::csi_pins_t pins_o,
  input wire logic transfer_end_irq,
  input wire logic slot_tick_irq,
  input wire logic target_slave_flag,
  input wire logic halted
);
  import csi_pkg::*;
  logic sel_n;
  logic seen_q;
  logic [4:0] low_q;
  logic [15:0] gap_q;
  assign sel_n = pins_o.slave_one_select_n & pins_o.slave_two_select_n;
  // clock-low length and slot gap; the first tick has no gap to judge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= 5'h00;
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      low_q <= pins_o.serial_clock_out ? 5'h00 : low_q + 5'h01;
      gap_q <= slot_tick_irq ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= seen_q | slot_tick_irq;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rate; $rose(pins_o.serial_clock_out) |-> low_q == 5'(HALF_BIT_CYC); endproperty
  a_rate: assert property (p_rate) else $error("half bit length wrong");
  property p_slot; seen_q && slot_tick_irq |-> gap_q == 16'h9bff; endproperty
  a_slot: assert property (p_slot) else $error("slot interval wrong");
  property p_excl; pins_o.slave_one_select_n || pins_o.slave_two_select_n; endproperty
  a_excl: assert property (p_excl) else $error("both slaves selected");
  property p_flag; !sel_n |-> pins_o.slave_one_select_n == target_slave_flag; endproperty
  a_flag: assert property (p_flag) else $error("wrong slave selected");
  property p_tick; slot_tick_irq && sel_n && !halted |=>
    (target_slave_flag ? !pins_o.slave_two_select_n : !pins_o.slave_one_select_n); endproperty
  a_tick: assert property (p_tick) else $error("tick did not select");
  property p_tmo; $fell(sel_n) |-> ##[1:406] (!busy_in || sel_n); endproperty
  a_tmo: assert property (p_tmo) else $error("busy wait too long");
  property p_idle; sel_n |-> pins_o.serial_clock_out; endproperty
  a_idle: assert property (p_idle) else $error("clock not idle high");
  property p_irq; transfer_end_irq |=> !transfer_end_irq [*8]; endproperty
  a_irq: assert property (p_irq) else $error("transfer end too soon");
  c_tick: cover property (slot_tick_irq);
  c_char: cover property (transfer_end_irq);
  // a clean finish deselects three cycles after the last transfer end; an abort does not
  c_abort: cover property ($rose(sel_n) && !$past(transfer_end_irq, 3));
endmodule

// [bench/slave_pair.sv]
// two busy-handshaking slaves sharing one return data line
`timescale 1ns/1ps
module slave_pair (
  input wire logic clk,
  input wire csi_pkg::csi_pins_t pins,
  input wire logic [1:0] ready,
  input wire logic [8:0] dly,
  input wire logic [7:0] stat,
  output logic sdi,
  output logic busy
);
  import csi_pkg::*;
  logic [7:0] log_q [0:31];
  logic [7:0] prev_q [0:1][0:7];
  logic [7:0] sh, tx, cmd;
  logic act, idx, bit_o;
  logic flt = 1'b0;
  int nlog = 0;
  int nb = 0;
  int nbit = 0;
  int wt = 0;
  assign act = !(pins.slave_one_select_n && pins.slave_two_select_n);
  assign idx = !pins.slave_two_select_n;
  // pulled up while idle, low once ready dly cycles after select
  assign busy = !(act && ready[idx] && wt >= int'(dly));
  // unselected slaves float, so the line shows a changing pattern
  assign sdi = act ? bit_o : flt;
  // select timer and float pattern
  always @(posedge clk) begin
    flt <= ~flt;
    wt <= act ? wt + 1 : 0;
    if (!act) nb = 0;
    if (!act) nbit = 0;
  end
  // drive on the falling edge, msb first
  always @(negedge pins.serial_clock_out) if (act) begin
    if (nbit == 0) tx = (nb == 0 || cmd == CMD_STATUS) ? stat : ~prev_q[idx][nb-1];
    bit_o = tx[7 - nbit];
  end
  // sample on the rising edge, log whole characters
  always @(posedge pins.serial_clock_out) if (act) begin
    sh = {sh[6:0], pins.serial_data_out};
    nbit = nbit + 1;
    if (nbit == 8) begin
      log_q[nlog] = sh;
      nlog = nlog + 1;
      if (nb == 0) cmd = sh;
      else if (cmd[7] && nb < 9) prev_q[idx][nb-1] = sh;
      nb = nb + 1;
      nbit = 0;
    end
  end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the slot-based serial master
`timescale 1ns/1ps
module tb_top;
  import csi_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] ready = 2'h3;
  logic [8:0] dly = 9'h005;
  logic sdi, busy, te, tick, flag, halted;
  csi_pins_t pins;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nte = 0;
  int t_tick = 0;
  initial forever #12.5 clk = ~clk;
  // cycle and transfer-end counters
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (te === 1'b1) nte <= nte + 1;
  end
  csi_master_slot_handshake i_csi_master_slot_handshake (.clk(clk), .rst_b(rst_b),
    .serial_data_in(sdi), .busy_in(busy), .pins_o(pins), .transfer_end_irq(te),
    .slot_tick_irq(tick), .target_slave_flag(flag), .halted(halted));
  // status reply offers 63 characters, more than the buffer holds
  slave_pair i_slave_pair (.clk(clk), .pins(pins), .ready(ready), .dly(dly),
    .stat(8'h7f), .sdi(sdi), .busy(busy));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // wait for a tick, check the select, then wait out the selection
  task automatic slot(input logic [1:0] exp, output int t0, output int len);
    int n;
    n = 0;
    while (tick !== 1'b1 && n < 41000) begin
      step;
      n++;
    end
    // a tick that never comes counts as a mismatch, not a silent pass
    check("tick wait", 16'(n < 41000), 16'h0001);
    t0 = cyc;
    step;
    check("select", 16'({pins.slave_one_select_n, pins.slave_two_select_n}), 16'(exp));
    n = cyc;
    while ((pins.slave_one_select_n & pins.slave_two_select_n) !== 1'b1 && cyc - n < 9000) step;
    len = cyc - n;
    check("deselect wait", 16'(len < 9000), 16'h0001);
    step;
  endtask
  task automatic t_reset;
    repeat (3) step;
    check("pins", 16'(pins), 16'h000f);
    check("outs", 16'({te, tick, flag, halted}), 16'h0000);
    repeat (3) step;
    rst_b = 1'b1;
  endtask
  task automatic t_status;
    int t0, len;
    slot(2'b01, t0, len);
    check("first tick", 16'(t0 > 39935 && t0 < 39950), 16'h0001);
    check("chars", 16'(i_slave_pair.nlog), 16'h0002);
    check("cmd", 16'(i_slave_pair.log_q[0]), 16'(CMD_STATUS));
    check("te", 16'(nte), 16'h0002);
    check("flag", 16'(flag), 16'h0000);
    t_tick = t0;
  endtask
  // slow slave: busy low 350 cycles after select, inside the limit
  task automatic t_tx;
    int t0, len;
    dly = 9'h15e;
    slot(2'b01, t0, len);
    check("slot gap", 16'(t0 - t_tick), 16'h9c00);
    check("tx cmd", 16'(i_slave_pair.log_q[2]), 16'h0088);
    for (int k = 0; k < 8; k++) begin
      check("tx data", 16'(i_slave_pair.log_q[3 + k]), 16'(k));
    end
    check("te", 16'(nte), 16'h000b);
    check("flag", 16'(flag), 16'h0000);
  endtask
  // slave one never answers: abort and switch
  task automatic t_timeout;
    int t0, len;
    ready = 2'b10;
    slot(2'b01, t0, len);
    check("abort time", 16'(len > 398 && len < 410), 16'h0001);
    check("chars", 16'(i_slave_pair.nlog), 16'h000b);
    check("flag", 16'(flag), 16'h0001);
    check("halted", 16'(halted), 16'h0000);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: three slots plus margin
  initial begin
    #3300000;
    err_count++;
    report_and_stop;
  end
  initial begin
    t_reset;
    t_status;
    t_tx;
    t_timeout;
    report_and_stop;
  end
endmodule
bind csi_master_slot_handshake csi_checker i_csi_checker (.clk(clk), .rst_b(rst_b),
  .busy_in(busy_in), .pins_o(pins_o), .transfer_end_irq(transfer_end_irq),
  .slot_tick_irq(slot_tick_irq), .target_slave_flag(target_slave_flag), .halted(halted));
